// >>> hdl/sarseq_consts.vh
`ifndef SARSEQ_CONSTS_VH
`define SARSEQ_CONSTS_VH
// Code width and straight binary anchors
`define SARSEQ_BITS 16
`define SARSEQ_CODE_ZERO 16'h0000
`define SARSEQ_CODE_MID 16'h8000
`define SARSEQ_CODE_FULL 16'hffff
// One-hot state codes
`define SARSEQ_ST_ACQ 5'h01
`define SARSEQ_ST_OPEN 5'h02
`define SARSEQ_ST_HOLD 5'h04
`define SARSEQ_ST_TRIAL 5'h08
`define SARSEQ_ST_DONE 5'h10
// Conversion clock divider: internal tick every N system clocks
`define SARSEQ_CONV_DIV 8'h02
// Comparator settle, in conversion ticks, per trial
`define SARSEQ_SETTLE 4'h1
`endif

// >>> hdl/sarseq_core.v
`timescale 1ns/10ps
`include "sarseq_consts.vh"
// Functional notes
// RULE1 - Convert strobe rising edge starts conversion
// RULE2 - Open sample switches, then hold inputs
// RULE3 - Sixteen-bit successive approximation, MSB first
// RULE4 - After trials, reacquire, present code, flag done
// RULE5 - Internal conversion clock times all trials
// RULE6 - Code belongs to its own strobe
// RULE7 - Core in low power between conversions
// RULE8 - Straight binary output, saturating at rails
// RULE9 - Keep trial bit when comparator says above
module sarseq_core #(
  parameter BITS = `SARSEQ_BITS,
  parameter [7:0] CONV_DIV = `SARSEQ_CONV_DIV
)(
  // Clock and reset
  input wire clk,
  input wire resetn,
  input wire clk_en,
  // Host strobe (pin)
  input wire convert_strobe,
  // Comparator result (analog side, asynchronous)
  input wire comp_above,
  // Analog switch controls
  output reg pos_sample_switch,
  output reg neg_sample_switch,
  output reg array_to_input,
  output reg [BITS-1:0] dac_trial,
  output reg core_power_on,
  // Result to host
  output reg [BITS-1:0] code,
  output reg busy,
  output reg conv_done
);

  reg [4:0] state;
  reg strobe_s1;
  reg strobe_s2;
  reg strobe_q;
  reg comp_s1;
  reg comp_s2;
  reg [7:0] div_cnt;
  reg [3:0] settle_cnt;
  reg [BITS-1:0] bit_mask;
  wire strobe_rise;
  wire conv_tick;
  wire [BITS-1:0] next_trial;

  // One-hot sequencer states
  localparam [4:0] ST_ACQ = `SARSEQ_ST_ACQ;
  localparam [4:0] ST_OPEN = `SARSEQ_ST_OPEN;
  localparam [4:0] ST_HOLD = `SARSEQ_ST_HOLD;
  localparam [4:0] ST_TRIAL = `SARSEQ_ST_TRIAL;
  localparam [4:0] ST_DONE = `SARSEQ_ST_DONE;

  // Code patterns follow BITS, so a narrower core still starts at its own MSB
  localparam [BITS-1:0] CODE_CLEAR = {BITS{1'b0}};
  localparam [BITS-1:0] TRIAL_MSB = {1'b1, {(BITS-1){1'b0}}};

  // Divider and settle counter end points
  // CONV_DIV must be at least one, or DIV_LAST wraps to 255 and the divider ticks only every 256 clocks
  localparam [7:0] DIV_CLEAR = 8'h00;
  localparam [7:0] DIV_STEP = 8'h01;
  localparam [7:0] DIV_LAST = CONV_DIV - DIV_STEP;
  localparam [3:0] SETTLE_CLEAR = 4'h0;
  localparam [3:0] SETTLE_STEP = 4'h1;

  // Two-flop synchronisers; only second stage is read
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_q <= 1'b0;
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
    end
    else if (clk_en)
    begin
      strobe_s1 <= convert_strobe;
      strobe_s2 <= strobe_s1;
      strobe_q <= strobe_s2;
      comp_s1 <= comp_above;
      comp_s2 <= comp_s1;
    end
  end

  assign strobe_rise = strobe_s2 & ~strobe_q; // see RULE1

  // Internal conversion clock; runs only while converting so idle burns nothing
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      div_cnt <= DIV_CLEAR;
    else if (clk_en)
    begin
      if (state == ST_ACQ || div_cnt == DIV_LAST)
        div_cnt <= DIV_CLEAR;
      else
        div_cnt <= div_cnt + DIV_STEP; // see RULE5
    end
  end

  assign conv_tick = (state != ST_ACQ) && (div_cnt == DIV_LAST);

  // Per-bit trial update: the bit under test takes the comparator verdict,
  // the bit just below it is raised for the next trial, all others hold
  genvar k;
  generate
    for (k = 0; k < BITS; k = k + 1)
    begin : g_trial_bit
      if (k == BITS - 1)
      begin : g_top
        // Nothing above the MSB can raise it
        assign next_trial[k] = bit_mask[k] ? comp_s2 : dac_trial[k]; // see RULE9
      end
      else
      begin : g_low
        assign next_trial[k] = bit_mask[k] ? comp_s2 : (bit_mask[k + 1] | dac_trial[k]); // see RULE9
      end
    end
  endgenerate

  // Sequencer: edges during a conversion are ignored, not queued, so a
  // host that strobes too early simply loses that strobe
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_ACQ;
      pos_sample_switch <= 1'b1;
      neg_sample_switch <= 1'b1;
      array_to_input <= 1'b1;
      dac_trial <= CODE_CLEAR;
      bit_mask <= CODE_CLEAR;
      settle_cnt <= SETTLE_CLEAR;
      core_power_on <= 1'b0;
      code <= CODE_CLEAR;
      busy <= 1'b0;
      conv_done <= 1'b0;
    end
    else if (clk_en)
    begin
      // Completion is a single-cycle pulse: cleared each cycle unless the done state sets it
      conv_done <= 1'b0;
      case (state)
        ST_ACQ:
        begin
          // Core stays unpowered while the arrays track the inputs
          core_power_on <= 1'b0; // see RULE7
          if (strobe_rise)
          begin
            state <= ST_OPEN; // see RULE1
            core_power_on <= 1'b1;
            busy <= 1'b1;
            // Comparator-side switches open first, before the arrays leave the inputs, as busy and power rise
            pos_sample_switch <= 1'b0; // see RULE2
            neg_sample_switch <= 1'b0;
          end
        end
        ST_OPEN:
        begin
          // One conversion tick later the arrays leave the inputs for ground
          if (conv_tick)
          begin
            array_to_input <= 1'b0; // see RULE2
            state <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          // First trial puts the MSB up
          if (conv_tick)
          begin
            bit_mask <= TRIAL_MSB; // see RULE3
            dac_trial <= TRIAL_MSB;
            settle_cnt <= `SARSEQ_SETTLE;
            state <= ST_TRIAL;
          end
        end
        ST_TRIAL:
        begin
          // With CONV_DIV of two or more, the settle ticks also cover the comparator synchroniser delay
          if (conv_tick)
          begin
            if (settle_cnt != SETTLE_CLEAR)
              settle_cnt <= settle_cnt - SETTLE_STEP;
            else
            begin
              // Keep or drop the bit, then try the next lower one
              dac_trial <= next_trial; // see RULE9
              bit_mask <= bit_mask >> 1; // see RULE3
              settle_cnt <= `SARSEQ_SETTLE;
              // Last bit decided: leave after this trial
              if (bit_mask[0])
                state <= ST_DONE;
            end
          end
        end
        ST_DONE:
        begin
          // Rails fall out naturally: all keeps give full, none give zero
          code <= dac_trial; // see RULE6, see RULE8
          pos_sample_switch <= 1'b1; // see RULE4
          neg_sample_switch <= 1'b1;
          array_to_input <= 1'b1;
          busy <= 1'b0;
          conv_done <= 1'b1; // see RULE4
          core_power_on <= 1'b0; // see RULE7
          state <= ST_ACQ;
        end
        default:
        begin
          // Unreachable code; fall back to acquisition
          state <= ST_ACQ;
        end
      endcase
    end
  end

endmodule

// >>> tb/sarseq_checker.sv
`timescale 1ns/10ps
module sarseq_checker(
  // Clock, reset and host side
  input wire clk, input wire resetn, input wire clk_en, input wire convert_strobe, input wire comp_above,
  // Switches and trial
  input wire pos_sample_switch, input wire neg_sample_switch, input wire array_to_input,
  input wire [15:0] dac_trial, input wire core_power_on,
  // Result
  input wire [15:0] code, input wire busy, input wire conv_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_strobe_starts: assert property ($rose(convert_strobe) && !busy |-> ##[1:4] busy) else $error("no start");
  a_open_first: assert property ($fell(array_to_input) |-> !pos_sample_switch) else $error("hold early");
  a_switch_pair: assert property (pos_sample_switch == neg_sample_switch) else $error("split");
  a_msb_first: assert property ($rose(busy) |-> ##[1:12] dac_trial == 16'h8000) else $error("msb");
  a_done_ends: assert property (conv_done |-> !busy && array_to_input) else $error("end");
  a_done_pulse: assert property (conv_done |=> !conv_done) else $error("pulse");
  a_own_timing: assert property ($rose(busy) |-> ##[40:100] conv_done) else $error("slow");
  a_code_holds: assert property (!conv_done |-> $stable(code)) else $error("code moved");
  a_idle_power: assert property (!busy |-> !core_power_on) else $error("power");
  c_start: cover property ($rose(busy));
  c_full: cover property (conv_done && code == 16'hffff);
  c_zero: cover property (conv_done && code == 16'h0000);
endmodule
bind sarseq_core sarseq_checker i_chk(.clk, .resetn, .clk_en, .convert_strobe, .comp_above, .pos_sample_switch,
  .neg_sample_switch, .array_to_input, .dac_trial, .core_power_on, .code, .busy, .conv_done);

// >>> tb/sarseq_comp_model.sv
`timescale 1ns/10ps
module sarseq_comp_model(
  // Trial level and held input in LSB units; above range saturates
  input wire [15:0] dac_trial,
  input wire [16:0] vin,
  output wire comp_above
);
  // Ideal comparator, held input stays still during a conversion
  assign comp_above = {1'b0, dac_trial} <= vin;
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  reg clk = 0, resetn = 0, strobe = 0, en = 1;
  reg [16:0] vin = 0;
  integer seed = 32'h8d07, mismatches = 0, num_checks = 0, i, n;
  wire comp, ps, ns, arr, pwr, busy, done;
  wire [15:0] dac, code;
  sarseq_core i_sarseq_core(.clk(clk), .resetn(resetn), .clk_en(en), .convert_strobe(strobe), .comp_above(comp),
    .pos_sample_switch(ps), .neg_sample_switch(ns), .array_to_input(arr), .dac_trial(dac), .core_power_on(pwr),
    .code(code), .busy(busy), .conv_done(done));
  sarseq_comp_model i_sarseq_comp_model(.dac_trial(dac), .vin(vin), .comp_above(comp));
  initial forever #5 clk = ~clk;
  task check(input [15:0] seen, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // One conversion; g re-pulses the strobe while busy, which must be ignored
  task convert(input [16:0] v, input g);
    integer b, r;
    reg [15:0] held;
    begin
      r = 0;
      for (b = 15; b >= 0; b = b - 1)
        if (v >= (r | (1 << b))) r = r | (1 << b);
      vin = v;
      strobe = 1;
      if (g)
      begin
        repeat (20) @(posedge clk);
        #1 strobe = 0;
        repeat (4) @(posedge clk);
        #1 strobe = 1;
        // Clock enable low mid-conversion must freeze the trial in progress
        repeat (4) @(posedge clk);
        #1 en = 0;
        held = dac;
        repeat (6) @(posedge clk);
        #1 check(dac, held);
        en = 1;
      end
      n = 0;
      while (done !== 1'b1 && n < 200)
      begin
        @(posedge clk);
        #1 n = n + 1;
      end
      if (n == 200) mismatches = mismatches + 1;
      if (n == 200) give_verdict;
      check(code, r[15:0]);
      check({12'h000, busy, arr, ps, pwr}, 16'h0006);
      strobe = 0;
      repeat (4) @(posedge clk);
      #1 $display("conversion of %h gave %h", v, code);
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    #1 resetn = 1;
    check({10'h000, ps, ns, arr, pwr, busy, done}, 16'h0038);
    convert(17'h00000, 0);
    convert(17'h08000, 1);
    convert(17'h0ffff, 0);
    convert(17'h1ffff, 1);
    for (i = 0; i < 8; i = i + 1)
      convert($random(seed) & 17'h1ffff, i[0]);
    give_verdict;
  end
endmodule
